// ---- dv/wsd_bridge_model.sv ----
// behavioural bridge driver stage loading the four outputs
`timescale 1ns/1ps
module wsd_bridge_model (
    input  wire logic       clock,
    input  wire logic [3:0] drive,
    input  wire logic [3:0] drive_en,
    output logic      [3:0] pin,
    output int              overlap
);
    // released gate lines sink through pull-downs, so a hi-z output reads low
    assign pin = drive & drive_en;
    initial overlap = 0;
    // both switches of one leg on together would short the rail
    always @(posedge clock) begin
        if ((pin[0] && pin[1]) || (pin[2] && pin[3])) begin
            overlap <= overlap + 1;
        end
    end
endmodule

// ---- dv/wsd_shutdown_tb.sv ----
// self-checking bench for the shutdown and dead-band block
`timescale 1ns/1ps
module wsd_shutdown_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, irq;
    logic        dat = 1'b0, ifo = 1'b0;
    logic [4:0]  sel = 5'h00;
    logic [1:0]  ph = 2'h0;
    logic [7:0]  trip = 8'h00, v;
    logic [3:0]  wave_out, wave_oe, pin, lv;
    logic [17:0] src;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    int          err_total = 0, checked = 0, overlap, i, r0, f0, tr, tf;

    assign src = 18'(dat) << sel;
    always #4 clock = ~clock;
    // oscillator tick every fourth system clock
    always @(posedge clock) begin
        ph <= ph + 2'h1;
        ifo <= (ph == 2'h3);
    end

    wsd_shutdown dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_sources(src), .internal_fast_oscillator(ifo),
        .logic_cell_4_output(trip[7]), .logic_cell_2_output(trip[6]),
        .comparator_2_output(trip[5]), .comparator_1_output(trip[4]),
        .timer_6_postscaled(trip[3]), .timer_4_postscaled(trip[2]),
        .timer_2_postscaled(trip[1]), .remappable_pin_input(trip[0]),
        .wave_out(wave_out), .wave_oe(wave_oe), .irq(irq));
    wsd_bridge_model bridge (.clock(clock), .drive(wave_out), .drive_en(wave_oe), .pin(pin),
        .overlap(overlap));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask
    // one transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [13:0] x, input logic [7:0] d);
        apb(1'b1, {x, 2'b00}, d);
    endtask
    task automatic rd(input logic [13:0] x, input logic [7:0] m, input logic [7:0] ex,
                      input logic [1:0] lo = 2'b00, input logic ee = 1'b0);
        exp_q.push_back({m, ee, ex});
        apb(1'b0, {x, lo}, 8'h00);
    endtask
    task automatic pins(input logic [3:0] oe, input logic [3:0] ov);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({wave_oe, pin}, {oe, ov & oe});
        @(posedge clock);
    endtask
    task automatic wb(input int b, input logic lvl, output int n);
        n = 0;
        while (wave_out[b] !== lvl || wave_oe[b] !== 1'b1) begin
            @(posedge clock);
            n++;
            if (n > 400) begin
                err_total++;
                test_done();
            end
        end
    endtask
    // edge-to-output latency of both dead-band paths
    task automatic db(input logic [5:0] r, input logic [5:0] f, output int dr, output int df);
        wr(wsd_pkg::IDX_RISE, {2'b00, r});
        wr(wsd_pkg::IDX_FALL, {2'b00, f});
        dat <= 1'b0;
        wb(1, 1'b1, df);
        repeat (2) @(posedge clock);
        dat <= 1'b1;
        wb(0, 1'b1, dr);
        repeat (2) @(posedge clock);
    endtask

    // read results are compared in order of issue
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: unexpected read", $time);
            end else begin
                e = exp_q.pop_front();
                chk({pslverr, prdata[7:0] & e[16:9]}, {e[8], e[7:0] & e[16:9]});
            end
        end
    end

    initial begin
        v = 8'($urandom(27));
        sel = 5'($urandom % 18);
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(wsd_pkg::IDX_CON0, 8'hFF, 8'h00);
        rd(wsd_pkg::IDX_AS0, 8'hFF, 8'h14);
        rd(wsd_pkg::IDX_AS1, 8'hFF, 8'h00);
        rd(wsd_pkg::IDX_IST, 8'hFF, 8'h00);
        rd(14'h0617, 8'h00, 8'h00, 2'b00, 1'b1);
        rd(wsd_pkg::IDX_AS1, 8'h00, 8'h00, 2'b01, 1'b1);
        // counts survive a later reset
        v = 8'($urandom);
        wr(wsd_pkg::IDX_RISE, 8'h2A);
        wr(wsd_pkg::IDX_FALL, v & 8'h3F);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(wsd_pkg::IDX_RISE, 8'h3F, 8'h2A);
        rd(wsd_pkg::IDX_FALL, 8'h3F, v & 8'h3F);
        $display("register test done");
        for (i = 0; i < 4; i++) begin
            lv = 4'(16'hEB7D >> (4 * i));
            v = {2'b10, lv, 2'b00};
            wr(wsd_pkg::IDX_AS0, v);
            pins({2{lv[3:2] != 2'h1, lv[1:0] != 2'h1}}, {2{lv[3:2] == 2'h3, lv[1:0] == 2'h3}});
            rd(wsd_pkg::IDX_AS0, 8'hFC, v);
        end
        $display("disabled shutdown test done");
        // zero counts so the first data rise shows at once
        wr(wsd_pkg::IDX_RISE, 8'h00);
        wr(wsd_pkg::IDX_FALL, 8'h00);
        wr(wsd_pkg::IDX_CLK, 8'h00);
        wr(wsd_pkg::IDX_ISM, {3'h0, sel});
        wr(wsd_pkg::IDX_AS0, 8'h14);
        wr(wsd_pkg::IDX_CON0, 8'h80);
        pins(4'h0, 4'h0);
        dat <= 1'b1;
        pins(4'hF, 4'h5);
        db(6'h00, 6'h00, r0, f0);
        v = 8'($urandom % 62 + 1);
        db(v[5:0], 6'h3F, tr, tf);
        chk(tr >= r0 + v && tr <= r0 + v + 1, 1);
        chk(tf >= f0 + 63 && tf <= f0 + 64, 1);
        wr(wsd_pkg::IDX_CLK, 8'h01);
        db(6'h03, 6'h01, tr, tf);
        chk(tr > r0 + 3 && tr <= r0 + 17, 1);
        wr(wsd_pkg::IDX_CLK, 8'h00);
        wr(wsd_pkg::IDX_RISE, 8'h00);
        wr(wsd_pkg::IDX_FALL, 8'h00);
        $display("dead band test done");
        wr(wsd_pkg::IDX_AS0, 8'h38);
        for (i = 0; i < 8; i++) begin
            wr(wsd_pkg::IDX_IMASK, 8'(i % 2));
            rd(wsd_pkg::IDX_IST, 8'h00, 8'h00);
            wr(wsd_pkg::IDX_AS1, 8'h01 << ((i + 1) % 8));
            trip <= 8'h01 << i;
            pins(4'hF, 4'h5);
            wr(wsd_pkg::IDX_AS1, 8'h01 << i);
            pins(4'hF, 4'hA);
            chk(irq, i % 2);
            rd(wsd_pkg::IDX_AS0, 8'hC0, 8'h80);
            rd(wsd_pkg::IDX_IST, 8'h01, 8'h01);
            trip <= 8'h00;
            pins(4'hF, 4'hA);
            chk(irq, 0);
            rd(wsd_pkg::IDX_AS0, 8'h80, 8'h80);
            wr(wsd_pkg::IDX_AS0, 8'h38);
            dat <= 1'b0;
            pins(4'hF, 4'hA);
            dat <= 1'b1;
            pins(4'hF, 4'h5);
        end
        $display("trip source test done");
        wr(wsd_pkg::IDX_AS1, 8'h01);
        wr(wsd_pkg::IDX_AS0, 8'h78);
        trip <= 8'h01;
        pins(4'hF, 4'hA);
        rd(wsd_pkg::IDX_AS0, 8'hC0, 8'hC0);
        trip <= 8'h00;
        pins(4'hF, 4'hA);
        rd(wsd_pkg::IDX_AS0, 8'hC0, 8'h40);
        dat <= 1'b0;
        pins(4'hF, 4'hA);
        dat <= 1'b1;
        pins(4'hF, 4'h5);
        $display("auto restart test done");
        // inactive level reached only after the dead band
        wr(wsd_pkg::IDX_AS0, 8'h00);
        wr(wsd_pkg::IDX_FALL, 8'h14);
        wr(wsd_pkg::IDX_RISE, 8'h1E);
        wr(wsd_pkg::IDX_CON1, 8'h05);
        pins(4'hF, 4'h0);
        trip <= 8'h01;
        wb(0, 1'b1, tf);
        chk(tf >= 20 && tf <= 25, 1);
        repeat (40) @(posedge clock);
        pins(4'hF, 4'h5);
        chk(overlap, 0);
        $display("inactive level test done");
        test_done();
    end
endmodule

// ---- verilog/wsd_pkg.sv ----
// constants of the waveform shutdown and dead-band block
package wsd_pkg;
    localparam int          ADDR_W      = 16;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CLK     = 14'h060C;
    localparam logic [13:0] IDX_ISM     = 14'h060D;
    localparam logic [13:0] IDX_RISE    = 14'h060E;
    localparam logic [13:0] IDX_FALL    = 14'h060F;
    localparam logic [13:0] IDX_CON0    = 14'h0610;
    localparam logic [13:0] IDX_CON1    = 14'h0611;
    localparam logic [13:0] IDX_AS0     = 14'h0612;
    localparam logic [13:0] IDX_AS1     = 14'h0613;
    localparam logic [13:0] IDX_STR     = 14'h0614;
    localparam logic [13:0] IDX_IST     = 14'h0615;
    localparam logic [13:0] IDX_IMASK   = 14'h0616;
    // field positions
    localparam int          B_EN        = 7;
    localparam int          B_LD        = 6;
    localparam int          B_IN        = 5;
    localparam int          B_SD        = 7;
    localparam int          B_REN       = 6;
    localparam int          B_BD_SAFE   = 4;
    localparam int          B_AC_SAFE   = 2;
    localparam int          B_IST_SD    = 0;
    localparam int          B_IST_RUN   = 1;
    // safe level codes
    localparam logic [1:0]  LS_INACT    = 2'h0;
    localparam logic [1:0]  LS_HIZ      = 2'h1;
    localparam logic [1:0]  LS_LOW      = 2'h2;
    localparam logic [1:0]  LS_HIGH     = 2'h3;
    localparam logic [1:0]  LS_RST      = 2'h1;
    localparam int          N_SRC       = 18;
endpackage

// ---- verilog/wsd_shutdown.sv ----
// auto-shutdown and dead-band generator with apb registers
// Operation
// R1 - status bit reads one while shutdown holds
// R2 - restart enable chooses auto or software restart
// R3 - b/d safe levels: high, low, hi-z
// R4 - b/d code zero: inactive after dead band
// R5 - a/c safe levels: high, low, hi-z
// R6 - a/c code zero: inactive after dead band
// R7 - shutdown bits writable while module disabled
// R8 - outputs resume at next data rising edge
// R9 - eight enables pick the trip sources
// R10 - rising dead band n to n+1 periods
// R11 - falling dead band n to n+1 periods
// R12 - zero count bypasses dead band
// R13 - dead-band counts not cleared by reset
// R14 - auto restart clears status when trips gone
// R15 - clock select picks oscillator or system clock
// R16 - enabled trip sets status, applies safe levels
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module wsd_shutdown #(
    parameter int DB_W = 6
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wsd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [wsd_pkg::N_SRC-1:0] data_sources,
    input  wire logic                      internal_fast_oscillator,
    input  wire logic                      logic_cell_4_output,
    input  wire logic                      logic_cell_2_output,
    input  wire logic                      comparator_2_output,
    input  wire logic                      comparator_1_output,
    input  wire logic                      timer_6_postscaled,
    input  wire logic                      timer_4_postscaled,
    input  wire logic                      timer_2_postscaled,
    input  wire logic                      remappable_pin_input,
    output logic      [3:0]                wave_out,
    output logic      [3:0]                wave_oe,
    output logic                           irq
);
    if (DB_W != 6) begin : g_chk
        $error("wsd_shutdown: DB_W must be 6");
    end

    typedef struct packed {
        logic             cs;
        logic [4:0]       ism;
        logic             en;
        logic             ld;
        logic [2:0]       mode;
        logic [3:0]       pol;
        logic             sd;
        logic             ren;
        logic [1:0]       bd_safe;
        logic [1:0]       ac_safe;
        logic [7:0]       trip_source_enable;
        logic [7:0]       str;
        logic             din;
        logic             a_lvl;
        logic             b_lvl;
        logic [DB_W-1:0]  cnt;
        logic             hold;
        logic [DB_W-1:0]  ac_cnt;
        logic [DB_W-1:0]  bd_cnt;
        logic [3:0]       po;
        logic [3:0]       poe;
        logic [1:0]       ist;
        logic [1:0]       imask;
        logic             irq;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } wsd_state_s;

    typedef struct packed {
        logic [DB_W-1:0]  rise_delay_count;
        logic [DB_W-1:0]  fall_delay_count;
    } wsd_count_s;

    wsd_state_s s_q;
    wsd_state_s s_d;
    wsd_count_s c_q;
    wsd_count_s c_d;

    // counts down one step per generator tick, stops at zero
    function automatic logic [DB_W-1:0] step(input logic [DB_W-1:0] c, input logic t);
        step = (t && c != '0) ? c - 1'b1 : c;
    endfunction

    // safe level of one pin: {level, drive enable}
    function automatic logic [1:0] safe(input logic [1:0] ls, input logic norm,
                                        input logic pol, input logic done);
        case (ls)
            wsd_pkg::LS_HIGH: safe = 2'h3;
            wsd_pkg::LS_LOW:  safe = 2'h1;
            wsd_pkg::LS_HIZ:  safe = 2'h0;
            default:          safe = {done ? pol : norm, 1'b1};
        endcase
    endfunction

    logic        tick;
    logic        din_now;
    logic        rise;
    logic        fall;
    logic [7:0]  trips;
    logic        trip;
    logic        acc;
    logic        wr;
    logic        rd;
    logic [13:0] idx;
    logic        sd_wr;
    logic        sd_set;
    logic        sd_clr;
    logic        active;
    logic [1:0]  pin_a;
    logic [1:0]  pin_b;
    logic [1:0]  pin_c;
    logic [1:0]  pin_d;
    logic [7:0]  rbyte;
    logic        hit;

    always_comb begin
        s_d     = s_q;
        c_d     = c_q;
        // oscillator tick only paces dead band; system clock ticks every edge
        tick    = s_q.cs ? internal_fast_oscillator : 1'b1;  // [R15]
        din_now = (s_q.ism < 5'(wsd_pkg::N_SRC)) ? data_sources[s_q.ism] : 1'b0;
        rise    = din_now && !s_q.din;
        fall    = !din_now && s_q.din;
        trips   = {logic_cell_4_output, logic_cell_2_output, comparator_2_output,
                   comparator_1_output, timer_6_postscaled, timer_4_postscaled,
                   timer_2_postscaled, remappable_pin_input};
        trip    = |(trips & s_q.trip_source_enable);  // [R9]
        acc     = psel && penable && s_q.pready;
        wr      = acc && pwrite;
        rd      = acc && !pwrite;
        idx     = paddr[wsd_pkg::ADDR_W-1:2];
        hit     = 1'b1;
        rbyte   = 8'h00;
        case (idx)
            wsd_pkg::IDX_CLK:   rbyte = {7'h00, s_q.cs};
            wsd_pkg::IDX_ISM:   rbyte = {3'h0, s_q.ism};
            wsd_pkg::IDX_RISE:  rbyte = {2'h0, c_q.rise_delay_count};
            wsd_pkg::IDX_FALL:  rbyte = {2'h0, c_q.fall_delay_count};
            wsd_pkg::IDX_CON0:  rbyte = {s_q.en, s_q.ld, 3'h0, s_q.mode};
            wsd_pkg::IDX_CON1:  rbyte = {2'h0, s_q.din, 1'b0, s_q.pol};
            wsd_pkg::IDX_AS0:   rbyte = {s_q.sd, s_q.ren, s_q.bd_safe, s_q.ac_safe, 2'h0};  // [R1]
            wsd_pkg::IDX_AS1:   rbyte = s_q.trip_source_enable;
            wsd_pkg::IDX_STR:   rbyte = s_q.str;
            wsd_pkg::IDX_IST:   rbyte = {6'h00, s_q.ist};
            wsd_pkg::IDX_IMASK: rbyte = {6'h00, s_q.imask};
            default:            hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        // one wait state so read data and ready come from flip-flops
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && !hit;
        s_d.prdata  = (psel && penable && !s_q.pready && !pwrite && hit) ? {24'h0, rbyte}
                                                                         : 32'h0;
        sd_wr = 1'b0;
        if (wr && hit) begin
            case (idx)
                wsd_pkg::IDX_CLK:   s_d.cs = pwdata[0];
                wsd_pkg::IDX_ISM:   s_d.ism = pwdata[4:0];
                wsd_pkg::IDX_RISE:  c_d.rise_delay_count = pwdata[DB_W-1:0];
                wsd_pkg::IDX_FALL:  c_d.fall_delay_count = pwdata[DB_W-1:0];
                wsd_pkg::IDX_CON0: begin
                    s_d.en   = pwdata[wsd_pkg::B_EN];
                    // load request only accepted once already enabled
                    s_d.ld   = pwdata[wsd_pkg::B_LD] && s_q.en;
                    s_d.mode = pwdata[2:0];
                end
                wsd_pkg::IDX_CON1:  s_d.pol = pwdata[3:0];
                wsd_pkg::IDX_AS0: begin
                    sd_wr    = 1'b1;  // [R7]
                    s_d.ren  = pwdata[wsd_pkg::B_REN];
                    s_d.bd_safe = pwdata[wsd_pkg::B_BD_SAFE+:2];
                    s_d.ac_safe = pwdata[wsd_pkg::B_AC_SAFE+:2];
                end
                wsd_pkg::IDX_AS1:   s_d.trip_source_enable = pwdata[7:0];  // [R7]
                wsd_pkg::IDX_STR:   s_d.str = pwdata[7:0];
                wsd_pkg::IDX_IMASK: s_d.imask = pwdata[1:0];
                default:            s_d.imask = s_q.imask;
            endcase
        end
        // hardware set beats any clear in the same cycle
        sd_set = (trip && s_q.en) || (sd_wr && pwdata[wsd_pkg::B_SD]);  // [R16]
        sd_clr = (sd_wr && !pwdata[wsd_pkg::B_SD]) || (s_q.ren && !trip);  // [R2] [R14]
        if (sd_set) begin
            s_d.sd = 1'b1;
        end else if (sd_clr) begin
            s_d.sd = 1'b0;
        end
        // outputs stay safe until the first data rise after clearing
        if (s_d.sd) begin
            s_d.hold = 1'b1;
        end else if (rise) begin
            s_d.hold = 1'b0;  // [R8]
        end
        // dead-band engine; tick phase gives the n to n+1 spread
        s_d.din = din_now;
        s_d.cnt = step(s_q.cnt, tick);
        if (s_q.cnt == DB_W'(1) && tick) begin
            if (s_q.din) begin
                s_d.a_lvl = 1'b1;  // [R10]
            end else begin
                s_d.b_lvl = 1'b1;  // [R11]
            end
        end
        if (rise) begin
            s_d.b_lvl = 1'b0;
            s_d.a_lvl = (c_q.rise_delay_count == '0);  // [R12]
            s_d.cnt   = c_q.rise_delay_count;  // [R10]
            if (s_q.ld) begin
                s_d.ld = 1'b0;
            end
        end else if (fall) begin
            s_d.a_lvl = 1'b0;
            s_d.b_lvl = (c_q.fall_delay_count == '0);  // [R12]
            s_d.cnt   = c_q.fall_delay_count;  // [R11]
        end
        // safe-state dead band timers start at the shutdown event
        s_d.ac_cnt = step(s_q.ac_cnt, tick);
        s_d.bd_cnt = step(s_q.bd_cnt, tick);
        if (s_d.sd && !s_q.sd) begin
            s_d.ac_cnt = c_q.fall_delay_count;  // [R6]
            s_d.bd_cnt = c_q.rise_delay_count;  // [R4]
        end
        active = s_q.hold || s_q.sd;
        pin_a  = safe(s_q.ac_safe, s_q.a_lvl ^ s_q.pol[0], s_q.pol[0], s_q.ac_cnt == '0);  // [R5]
        pin_c  = safe(s_q.ac_safe, s_q.a_lvl ^ s_q.pol[2], s_q.pol[2], s_q.ac_cnt == '0);  // [R6]
        pin_b  = safe(s_q.bd_safe, s_q.b_lvl ^ s_q.pol[1], s_q.pol[1], s_q.bd_cnt == '0);  // [R3]
        pin_d  = safe(s_q.bd_safe, s_q.b_lvl ^ s_q.pol[3], s_q.pol[3], s_q.bd_cnt == '0);  // [R4]
        if (active) begin
            s_d.po  = {pin_d[1], pin_c[1], pin_b[1], pin_a[1]};
            s_d.poe = {pin_d[0], pin_c[0], pin_b[0], pin_a[0]};
        end else if (s_q.en) begin
            s_d.po  = {s_q.b_lvl ^ s_q.pol[3], s_q.a_lvl ^ s_q.pol[2],
                       s_q.b_lvl ^ s_q.pol[1], s_q.a_lvl ^ s_q.pol[0]};
            s_d.poe = 4'hF;
        end else begin
            s_d.po  = 4'h0;
            s_d.poe = 4'h0;
        end
        // sticky events, read clears, set wins
        if (rd && idx == wsd_pkg::IDX_IST) begin
            s_d.ist = 2'h0;
        end
        if (s_d.sd && !s_q.sd) begin
            s_d.ist[wsd_pkg::B_IST_SD] = 1'b1;
        end
        if (s_q.hold && !s_d.hold) begin
            s_d.ist[wsd_pkg::B_IST_RUN] = 1'b1;
        end
        s_d.irq = |(s_d.ist & s_q.imask);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q      <= '0;
            s_q.bd_safe <= wsd_pkg::LS_RST;
            s_q.ac_safe <= wsd_pkg::LS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // no reset: counts survive every reset and start undefined
    always_ff @(posedge clock) begin
        c_q <= c_d;  // [R13]
    end

    assign prdata   = s_q.prdata;
    assign pready   = s_q.pready;
    assign pslverr  = s_q.pslverr;
    assign wave_out = s_q.po;
    assign wave_oe  = s_q.poe;
    assign irq      = s_q.irq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence trip_seen;
        trip && s_q.en;
    endsequence
    sequence safe_on;
        s_q.sd && s_q.hold;
    endsequence

    a_trip_sets_sd: assert property (trip_seen |=> safe_on)  // [R16]
        else $error("enabled trip did not set shutdown");
    a_sd_reads_one: assert property (                        // [R1]
        psel && penable && !pready && !pwrite && idx == wsd_pkg::IDX_AS0
        |=> prdata[wsd_pkg::B_SD] == $past(s_q.sd))
        else $error("shutdown bit read wrong");
    a_ren_clears: assert property (                          // [R14]
        s_q.sd && s_q.ren && !trip && !sd_set |=> !s_q.sd)
        else $error("auto restart did not clear status");
    a_no_ren_keeps: assert property (                        // [R2]
        s_q.sd && !s_q.ren && !sd_wr |=> s_q.sd)
        else $error("status cleared without software");
    a_bd_high: assert property (                             // [R3]
        active && s_q.bd_safe == wsd_pkg::LS_HIGH |=> wave_out[1] && wave_oe[1])
        else $error("b safe high missing");
    a_ac_hiz: assert property (                              // [R5]
        active && s_q.ac_safe == wsd_pkg::LS_HIZ |=> !wave_oe[0] && !wave_oe[2])
        else $error("a/c not released");
    a_bd_low: assert property (                              // [R3]
        active && s_q.bd_safe == wsd_pkg::LS_LOW
        |=> !wave_out[1] && !wave_out[3] && wave_oe[1] && wave_oe[3])
        else $error("b/d safe low missing");
    a_bd_hiz: assert property (                              // [R3]
        active && s_q.bd_safe == wsd_pkg::LS_HIZ |=> !wave_oe[1] && !wave_oe[3])
        else $error("b/d not released");
    a_ac_high: assert property (                             // [R5]
        active && s_q.ac_safe == wsd_pkg::LS_HIGH
        |=> wave_out[0] && wave_out[2] && wave_oe[0] && wave_oe[2])
        else $error("a/c safe high missing");

    // code zero keeps the running waveform until the shutdown dead band expires
    a_ac_wait: assert property (                             // [R6]
        active && s_q.ac_safe == wsd_pkg::LS_INACT && s_q.ac_cnt != '0
        |=> wave_out[0] == $past(s_q.a_lvl ^ s_q.pol[0]))
        else $error("a left waveform before dead band");
    a_ac_inact: assert property (                            // [R6]
        active && s_q.ac_safe == wsd_pkg::LS_INACT && s_q.ac_cnt == '0
        |=> wave_out[0] == $past(s_q.pol[0]) && wave_oe[0])
        else $error("a not at inactive level");
    a_bd_inact: assert property (                            // [R4]
        active && s_q.bd_safe == wsd_pkg::LS_INACT && s_q.bd_cnt == '0
        |=> wave_out[1] == $past(s_q.pol[1]) && wave_oe[1])
        else $error("b not at inactive level");
    a_hold_until: assert property (                          // [R8]
        $fell(s_q.sd) ##0 !rise |=> s_q.hold)
        else $error("outputs released before data rise");
    // two-count dead band on the system clock: edge, two counts, then level
    sequence rise_two;
        rise && !s_q.cs && c_q.rise_delay_count == DB_W'(2);
    endsequence
    sequence fall_two;
        fall && !s_q.cs && c_q.fall_delay_count == DB_W'(2);
    endsequence

    a_rise_db: assert property (                             // [R10]
        rise_two ##1 (!fall)[*2] |=> s_q.a_lvl)
        else $error("rising dead band too long");
    a_rise_early: assert property (                          // [R10]
        rise_two |=> (!s_q.a_lvl)[*2])
        else $error("rising dead band too short");
    a_fall_db: assert property (                             // [R11]
        fall_two ##1 (!rise)[*2] |=> s_q.b_lvl)
        else $error("falling dead band too long");
    a_fall_early: assert property (                          // [R11]
        fall_two |=> (!s_q.b_lvl)[*2])
        else $error("falling dead band too short");
    a_bypass: assert property (                              // [R12]
        rise && c_q.rise_delay_count == '0 |=> s_q.a_lvl)
        else $error("zero count did not bypass");
    a_osc_pause: assert property (                           // [R15]
        s_q.cs && !internal_fast_oscillator && !rise && !fall |=> s_q.cnt == $past(s_q.cnt))
        else $error("dead band counted without oscillator tick");
    a_hold_clear: assert property (                          // [R8]
        s_q.hold && !s_d.sd && rise |=> !s_q.hold)
        else $error("outputs not resumed at data rise");
    a_ist_event: assert property (                           // [R16]
        $rose(s_q.sd) |-> s_q.ist[wsd_pkg::B_IST_SD])
        else $error("shutdown event not flagged");

    // one wait state, one-cycle answer
    a_ready_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("ready not given after one wait state");
    a_ready_once: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_bad_addr: assert property (
        psel && penable && !pready && !hit |=> pslverr)
        else $error("bad address not refused");
    a_irq_level: assert property (
        irq == |(s_q.ist & $past(s_q.imask)))
        else $error("interrupt level wrong");
endmodule
